/* design/bit_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : bit_sync
`default_nettype wire

/* design/bus_stop_watch.sv */
// Stop condition watcher on the system clock
`timescale 1ns/1ps
`default_nettype none
module bus_stop_watch (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      stop_tgl_q,
	output logic      stop_pulse_q
);
	logic [1:0] line_s;
	logic       sda_prev_q;
	logic       stop_now;
	logic       start_now;

	bit_sync #(.WIDTH(2)) u_line_sync (
		.clk   (clock),
		.rst_n (nrst),
		.din   ({scl_i, sda_i}),
		.dout  (line_s)
	);

	// Data rising while clock high
	assign stop_now = line_s[1] && line_s[0] && !sda_prev_q;
	// Data falling while clock high
	assign start_now = line_s[1] && !line_s[0] && sda_prev_q;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sda_prev_q <= 1'b1;
		end else begin
			sda_prev_q <= line_s[0];
		end
	end

	// Standby level: set by a stop, cleared by the next start
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stop_tgl_q   <= 1'b0;
			stop_pulse_q <= 1'b0;
		end else begin
			stop_pulse_q <= stop_now;
			if (stop_now) begin
				stop_tgl_q <= 1'b1;
			end else if (start_now) begin
				stop_tgl_q <= 1'b0;
			end
		end
	end

	stop_toggle_a: assert property (@(posedge clock) disable iff (!nrst)
		stop_now |=> stop_tgl_q && stop_pulse_q)
		else $error("stop not forwarded");
endmodule : bus_stop_watch
`default_nettype wire

/* design/rtc_read_pkg.sv */
// Constants shared by the serial read path of the clock device
// Function
// - Each word address byte is acknowledged, and the master may then issue a repeated start with a read address.
// - A matching read address is acknowledged and one data byte from the current address follows.
// - A stop after the word address bytes only loads the address counter and returns no data.
// - After a stop the device stands by and ignores the bus until a new start arrives.
// - A current address read returns data from the address counter: the address last loaded, plus one for each byte read since.
// - A sequential read opens like a current address or random read, and its first byte is the same.
// - Each byte the master acknowledges during a read is followed by another byte.
// - Successive read bytes come from consecutive addresses, the counter stepping by one per byte.
// - The seven address bits of the slave byte must match the fixed address exactly to be acknowledged.
// - The word address is two bytes from the master, high byte first.
// - The address counter is cleared to zero at reset.
// - A data byte left unacknowledged ends the transmission and releases the data line.
package rtc_read_pkg;
	localparam int          ADDR_W      = 16;
	localparam int          DEV_ADDR_W  = 7;
	localparam logic [3:0]  CNT_LAST    = 4'h7;
	localparam logic [3:0]  CNT_ACK     = 4'h8;
	localparam logic [3:0]  CNT_RST     = 4'h0;
	localparam logic [15:0] ADDR_RST    = 16'h0000;
	localparam logic [7:0]  BYTE_RST    = 8'h00;
	localparam logic        LINE_REL    = 1'b1;
	localparam logic        LINE_LOW    = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WADDR,
		ST_READ
	} link_state_e;
endpackage : rtc_read_pkg

/* design/rtc_serial_read_path.sv */
// Serial slave read path with word address counter
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_read_path #(
	parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary value
	parameter int         MEM_AW   = 6
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              scl,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_n,
	input  wire logic              wr_en,
	input  wire logic [MEM_AW-1:0] wr_addr,
	input  wire logic [7:0]        wr_data,
	output logic                   stop_seen
);
	logic [7:0]                      mem [2**MEM_AW];
	logic                            stop_tgl;
	logic                            lrst_n;
	logic                            stop_tgl_l;
	logic                            stop_evt;
	logic                            rx_bit_q;
	logic                            start_evt;
	rtc_read_pkg::link_state_e       state_q;
	logic [3:0]                      cnt_q;
	logic [7:0]                      sh_q;
	logic [7:0]                      tx_q;
	logic                            rw_q;
	logic                            hi_q;
	logic [7:0]                      addr_hi_q;
	logic [rtc_read_pkg::ADDR_W-1:0] addr_q;
	logic [7:0]                      rx_byte;
	logic [7:0]                      rd_byte;

	// Readable locations, filled from the system side
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	bus_stop_watch u_stop (
		.clock        (clock),
		.nrst         (nrst),
		.scl_i        (scl),
		.sda_i        (sda_i),
		.stop_tgl_q   (stop_tgl),
		.stop_pulse_q (stop_seen)
	);

	// Reset and stop event into the link domain
	bit_sync #(.WIDTH(1)) u_rst_sync (
		.clk   (scl),
		.rst_n (1'b1),
		.din   (nrst),
		.dout  (lrst_n)
	);

	bit_sync #(.WIDTH(1)) u_stop_sync (
		.clk   (scl),
		.rst_n (lrst_n),
		.din   (stop_tgl),
		.dout  (stop_tgl_l)
	);

	// Standby level; a stale copy right after a start is ignored
	assign stop_evt = stop_tgl_l
		&& !(state_q == rtc_read_pkg::ST_ADDR && cnt_q == rtc_read_pkg::CNT_RST);

	// Bit sampled at clock rise; a data rise marks the line high again
	always_ff @(posedge scl or posedge sda_i) begin
		if (sda_i) begin
			rx_bit_q <= 1'b1;
		end else if (!lrst_n) begin
			rx_bit_q <= 1'b1;
		end else begin
			rx_bit_q <= 1'b0;
		end
	end

	// Data fell while clock high
	assign start_evt = rx_bit_q && !sda_i;
	assign rx_byte   = {sh_q[6:0], rx_bit_q};
	assign rd_byte   = mem[addr_q[MEM_AW-1:0]];

	// Pin data is always low; the enable does the driving
	always_ff @(negedge scl) begin
		sda_o <= rtc_read_pkg::LINE_LOW;
	end

	// Link sequencer, updated while the clock is low
	always_ff @(negedge scl) begin
		if (!lrst_n) begin
			state_q   <= rtc_read_pkg::ST_IDLE;
			cnt_q     <= rtc_read_pkg::CNT_RST;
			sh_q      <= rtc_read_pkg::BYTE_RST;
			tx_q      <= rtc_read_pkg::BYTE_RST;
			rw_q      <= 1'b0;
			hi_q      <= 1'b1;
			addr_hi_q <= rtc_read_pkg::BYTE_RST;
			addr_q    <= rtc_read_pkg::ADDR_RST;
			sda_oe_n  <= rtc_read_pkg::LINE_REL;
		end else if (start_evt) begin
			state_q  <= rtc_read_pkg::ST_ADDR;
			cnt_q    <= rtc_read_pkg::CNT_RST;
			hi_q     <= 1'b1;
			sda_oe_n <= rtc_read_pkg::LINE_REL;
		end else if (stop_evt) begin
			state_q  <= rtc_read_pkg::ST_IDLE;
			sda_oe_n <= rtc_read_pkg::LINE_REL;
		end else begin
			unique case (state_q)
				rtc_read_pkg::ST_IDLE: begin
					sda_oe_n <= rtc_read_pkg::LINE_REL;
				end
				rtc_read_pkg::ST_ADDR: begin
					if (cnt_q < rtc_read_pkg::CNT_LAST) begin
						sh_q  <= rx_byte;
						cnt_q <= cnt_q + 4'h1;
					end else if (cnt_q == rtc_read_pkg::CNT_LAST) begin
						if (rx_byte[7:1] == DEV_ADDR) begin
							rw_q     <= rx_byte[0];
							sda_oe_n <= rtc_read_pkg::LINE_LOW;
							cnt_q    <= rtc_read_pkg::CNT_ACK;
						end else begin
							state_q <= rtc_read_pkg::ST_IDLE;
						end
					end else if (rw_q) begin
						tx_q     <= rd_byte;
						sda_oe_n <= rd_byte[7];
						state_q  <= rtc_read_pkg::ST_READ;
						cnt_q    <= rtc_read_pkg::CNT_RST;
					end else begin
						sda_oe_n <= rtc_read_pkg::LINE_REL;
						state_q  <= rtc_read_pkg::ST_WADDR;
						cnt_q    <= rtc_read_pkg::CNT_RST;
					end
				end
				rtc_read_pkg::ST_WADDR: begin
					if (cnt_q < rtc_read_pkg::CNT_LAST) begin
						sh_q  <= rx_byte;
						cnt_q <= cnt_q + 4'h1;
					end else if (cnt_q == rtc_read_pkg::CNT_LAST) begin
						sda_oe_n <= rtc_read_pkg::LINE_LOW;
						cnt_q    <= rtc_read_pkg::CNT_ACK;
						if (hi_q) begin
							addr_hi_q <= rx_byte;
						end else begin
							addr_q <= {addr_hi_q, rx_byte};
						end
					end else begin
						sda_oe_n <= rtc_read_pkg::LINE_REL;
						cnt_q    <= rtc_read_pkg::CNT_RST;
						hi_q     <= 1'b0;
						if (!hi_q) begin
							state_q <= rtc_read_pkg::ST_IDLE;
						end
					end
				end
				rtc_read_pkg::ST_READ: begin
					if (cnt_q < rtc_read_pkg::CNT_LAST) begin
						sda_oe_n <= tx_q[6];
						tx_q     <= {tx_q[6:0], 1'b1};
						cnt_q    <= cnt_q + 4'h1;
					end else if (cnt_q == rtc_read_pkg::CNT_LAST) begin
						sda_oe_n <= rtc_read_pkg::LINE_REL;
						addr_q   <= addr_q + 16'h0001;
						cnt_q    <= rtc_read_pkg::CNT_ACK;
					end else if (!rx_bit_q) begin
						tx_q     <= rd_byte;
						sda_oe_n <= rd_byte[7];
						cnt_q    <= rtc_read_pkg::CNT_RST;
					end else begin
						sda_oe_n <= rtc_read_pkg::LINE_REL;
						state_q  <= rtc_read_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	logic addr_match;
	assign addr_match = rx_byte[7:1] == DEV_ADDR;

	addr_ack_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_ADDR
		&& cnt_q == rtc_read_pkg::CNT_LAST && addr_match |=> !sda_oe_n
		##1 sda_oe_n == (rw_q ? $past(rd_byte[7]) : 1'b1))
		else $error("slave address not acknowledged");

	addr_nack_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_ADDR
		&& cnt_q == rtc_read_pkg::CNT_LAST && !addr_match |=> state_q == rtc_read_pkg::ST_IDLE && sda_oe_n)
		else $error("wrong slave address answered");

	waddr_ack_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_WADDR
		&& cnt_q == rtc_read_pkg::CNT_LAST |=> !sda_oe_n)
		else $error("word address byte not acknowledged");

	addr_load_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_WADDR && !hi_q
		&& cnt_q == rtc_read_pkg::CNT_LAST |=> addr_q == {$past(addr_hi_q), $past(rx_byte)})
		else $error("word address not loaded");

	first_bit_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_ADDR && rw_q
		&& cnt_q == rtc_read_pkg::CNT_ACK |=> state_q == rtc_read_pkg::ST_READ
		&& sda_oe_n == $past(rd_byte[7]) && tx_q == $past(rd_byte))
		else $error("first read byte wrong");

	addr_step_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_READ
		&& cnt_q == rtc_read_pkg::CNT_LAST |=> addr_q == $past(addr_q) + 16'h0001 && sda_oe_n)
		else $error("address counter did not step");

	read_more_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_READ
		&& cnt_q == rtc_read_pkg::CNT_ACK && !rx_bit_q |=> state_q == rtc_read_pkg::ST_READ
		&& cnt_q == rtc_read_pkg::CNT_RST ##7 cnt_q == rtc_read_pkg::CNT_LAST || start_evt || stop_evt)
		else $error("acknowledged read not continued");

	read_end_a: assert property (@(negedge scl) disable iff (!lrst_n)
		!start_evt && !stop_evt && state_q == rtc_read_pkg::ST_READ
		&& cnt_q == rtc_read_pkg::CNT_ACK && rx_bit_q |=> state_q == rtc_read_pkg::ST_IDLE
		&& sda_oe_n && $stable(addr_q))
		else $error("read not ended on missing acknowledge");

	standby_a: assert property (@(negedge scl) disable iff (!lrst_n)
		stop_evt && !start_evt |=> state_q == rtc_read_pkg::ST_IDLE && sda_oe_n)
		else $error("stop did not return to standby");

	idle_quiet_a: assert property (@(negedge scl) disable iff (!lrst_n)
		state_q == rtc_read_pkg::ST_IDLE && !start_evt |=> state_q == rtc_read_pkg::ST_IDLE && sda_oe_n)
		else $error("bus answered while standing by");

	reset_addr_a: assert property (@(negedge scl)
		!lrst_n |=> addr_q == rtc_read_pkg::ADDR_RST)
		else $error("address counter not cleared");
endmodule : rtc_serial_read_path
`default_nettype wire

/* test/bus_master_model.sv */
// Behavioural two-wire bus master for the read path bench
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	output logic      scl,
	output logic      pull_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// One bit, 80 ns, data set while clock low
	task automatic bit_out(input logic b, output logic s);
		pull_low = ~b;
		#20 scl = 1'b1;
		#20 s = sda;
		#20 scl = 1'b0;
		#20;
	endtask : bit_out
	// Clock pulses with the line released, then park high
	task automatic pulses(input int n);
		logic s;
		for (int i = 0; i < n; i++)
			bit_out(1'b1, s);
		#20 scl = 1'b1;
	endtask : pulses
	task automatic start_c();
		pull_low = 1'b0;
		#20 scl = 1'b1;
		#20 pull_low = 1'b1;
		#20 scl = 1'b0;
		#20;
	endtask : start_c
	task automatic stop_c();
		pull_low = 1'b1;
		#20 scl = 1'b1;
		#20 pull_low = 1'b0;
		#40;
	endtask : stop_c
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_out(b[i], s);
		bit_out(1'b1, s);
		ack = ~s;
	endtask : byte_out
	// Ack low for more data, high ends the read
	task automatic byte_in(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_out(1'b1, s);
			d[i] = s;
		end
		bit_out(~ack, s);
	endtask : byte_in
endmodule : bus_master_model
`default_nettype wire

/* test/rtc_serial_read_path_tb.sv */
// Self-checking bench for the serial read path
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_read_path_tb;
	localparam logic [6:0] DEV = 7'h2a; // Arbitrary value
	logic       clock;
	logic       nrst;
	logic       wr_en;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic       scl;
	logic       pull_low;
	logic       sda_o;
	logic       sda_oe_n;
	logic       stop_seen;
	wire logic  sda;
	int         err_total = 0;
	int         n_checks = 0;
	int         stops = 0;
	int         cyc = 0;

	assign sda = pull_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

	rtc_serial_read_path #(
		.DEV_ADDR(DEV),
		.MEM_AW  (6)
	) rtc_serial_read_path_i (
		.clock    (clock),
		.nrst     (nrst),
		.scl      (scl),
		.sda_i    (sda),
		.sda_o    (sda_o),
		.sda_oe_n (sda_oe_n),
		.wr_en    (wr_en),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.stop_seen(stop_seen)
	);
	bus_master_model master_i (
		.scl     (scl),
		.pull_low(pull_low),
		.sda     (sda)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (stop_seen === 1'b1)
			stops <= stops + 1;
		if (cyc == 20000) begin
			err_total++;
			$display("wrong value at %0t: timeout", $time);
			give_verdict();
		end
	end

	function automatic logic [7:0] pat(input int a);
		return 8'((a % 64) * 5 + 19);
	endfunction : pat

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic load();
		for (int a = 0; a < 64; a++) begin
			@(posedge clock);
			#1;
			wr_en = 1'b1;
			wr_addr = 6'(a);
			wr_data = pat(a);
		end
		@(posedge clock);
		#1 wr_en = 1'b0;
	endtask : load

	task automatic addr_set(input logic [15:0] a);
		logic k;
		master_i.start_c();
		master_i.byte_out({DEV, 1'b0}, k);
		chk({7'h00, k}, 8'h01, "write ack");
		master_i.byte_out(a[15:8], k);
		chk({7'h00, k}, 8'h01, "high ack");
		master_i.byte_out(a[7:0], k);
		chk({7'h00, k}, 8'h01, "low ack");
	endtask : addr_set

	task automatic rd(input int n, input int e);
		logic       k;
		logic [7:0] d;
		master_i.start_c();
		master_i.byte_out({DEV, 1'b1}, k);
		chk({7'h00, k}, 8'h01, "read ack");
		for (int i = 0; i < n; i++) begin
			master_i.byte_in(i < n - 1, d);
			chk(d, pat(e + i), "data");
		end
		#5 chk({7'h00, sda_oe_n}, 8'h01, "release");
		chk({7'h00, sda_o}, 8'h00, "pin level");
		master_i.stop_c();
	endtask : rd

	task automatic t_set_addr();
		logic k;
		int   s0;
		s0 = stops;
		addr_set(16'h0025);
		master_i.stop_c();
		repeat (10) @(posedge clock);
		chk(8'(stops - s0), 8'h01, "stop pulse");
		master_i.bit_out(1'b1, k);
		master_i.byte_out({DEV, 1'b1}, k);
		chk({7'h00, k}, 8'h00, "standby");
		master_i.stop_c();
		rd(1, 16'h0025);
	endtask : t_set_addr

	task automatic t_bad_addr();
		logic k;
		for (int j = 0; j < 7; j++) begin
			master_i.start_c();
			master_i.byte_out({DEV ^ 7'(1 << j), 1'b1}, k);
			chk({7'h00, k}, 8'h00, "bad addr");
			master_i.stop_c();
		end
		rd(1, 16'h0143);
	endtask : t_bad_addr

	initial begin
		nrst = 1'b0;
		wr_en = 1'b0;
		wr_addr = 6'h00;
		wr_data = 8'h00;
		master_i.pulses(5);
		@(posedge clock);
		#1 nrst = 1'b1;
		master_i.pulses(3);
		load();
		rd(1, 0);
		t_set_addr();
		addr_set(16'h013e);
		rd(4, 16'h013e);
		rd(1, 16'h0142);
		t_bad_addr();
		give_verdict();
	end
endmodule : rtc_serial_read_path_tb
`default_nettype wire
